// >>> src/aec_defs.svh
// Purpose: offsets, fixed values and reset values of the error reporting extended space
// Assumes: byte offsets within the 4 KB extended configuration space
// Notes:   definitions only
`ifndef AEC_DEFS_SVH
`define AEC_DEFS_SVH

`define AEC_OFF_CAP_ID       12'h100
`define AEC_OFF_NEXT_VER     12'h102
`define AEC_OFF_UNC_STATUS   12'h104
`define AEC_OFF_UNC_MASK     12'h108
`define AEC_OFF_UNC_SEVERITY 12'h10C
`define AEC_OFF_COR_STATUS   12'h110
`define AEC_OFF_COR_MASK     12'h114
`define AEC_OFF_CAP_CTRL     12'h118
`define AEC_OFF_HDR_LOG0     12'h11C
`define AEC_OFF_HDR_LOG1     12'h120
`define AEC_OFF_HDR_LOG2     12'h124
`define AEC_OFF_HDR_LOG3     12'h128
`define AEC_OFF_SEC_STATUS   12'h12C
`define AEC_OFF_SEC_MASK     12'h130
`define AEC_OFF_SEC_SEVERITY 12'h134
`define AEC_OFF_SEC_CTRL     12'h138
`define AEC_OFF_SEC_LOG0     12'h13C
`define AEC_OFF_SEC_LOG1     12'h140
`define AEC_OFF_SEC_LOG2     12'h144
`define AEC_OFF_SEC_LOG3     12'h148

`define AEC_CAP_ID_VAL       16'h0001
`define AEC_NEXT_PTR_VAL     12'h000
`define AEC_CAP_VER_VAL      4'h1

`define AEC_RST_WORD         32'h00000000
`define AEC_FEP_LSB          0
`define AEC_FEP_W            5

`endif

// >>> src/aec_pkg.sv
// Purpose: shared types of the error reporting extended space
// Assumes: nothing beyond aec_defs.svh
// Notes:   constants live in the header, types here
package aec_pkg;

  typedef logic [31:0] aec_word_t;
  typedef logic [4:0]  aec_ptr_t;

  // which reset events clear a bit
  typedef enum logic [1:0] {
    AEC_CLS_FUND   = 2'b00,
    AEC_CLS_STICKY = 2'b01,
    AEC_CLS_HOT    = 2'b10
  } aec_rst_class_t;

endpackage : aec_pkg

// >>> src/aec_top.sv
// Purpose: error reporting capability header and register bank of the extended configuration space
// Assumes: config requests and error events are synchronous to mclk_in; one request per ack
// Notes:   read data and ack appear one cycle after the request is taken
//
// Functional notes
// - capability identifier at 100h is read-only and always reads 0001h.
// - next-capability pointer at 102h upper 12 bits read 000h, ending the chain.
// - capability version in the low four bits of 102h reads 1h.
// - sticky bits clear only on global reset input or power-on reset.
// - ordinary bits clear on fundamental reset, global reset or power-on; hot-class bits also on hot reset.
// - header log registers clear on fundamental, global or power-on reset, not hot.
// - primary registers decode at 104h to 118h, header log words from 11Ch.
// - secondary registers decode at 12Ch to 138h, header log words from 13Ch.
// - uncorrectable status bits clear only by writing one; zero leaves them.
`include "aec_defs.svh"

module aec_top #(
  parameter logic [31:0] UNC_IMPL_MASK = 32'h001FF010,
  parameter logic [31:0] COR_IMPL_MASK = 32'h000031C1,
  parameter logic [31:0] SEC_IMPL_MASK = 32'h00001FFF,
  parameter logic [31:0] CTL_RW_MASK   = 32'h00000140,
  parameter logic [31:0] STICKY_MASK   = 32'h00000000,
  parameter logic [31:0] HOT_MASK      = 32'h00000000
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic         global_reset_n_in,
  input  wire logic         perst_n_in,
  input  wire logic         hot_reset_in,
  input  wire logic         cfg_req_in,
  input  wire logic         cfg_wr_in,
  input  wire logic [11:0]  cfg_addr_in,
  input  wire logic [3:0]   cfg_be_in,
  input  wire logic [31:0]  cfg_wdata_in,
  input  wire logic [31:0]  unc_evt_in,
  input  wire logic [31:0]  cor_evt_in,
  input  wire logic [31:0]  sec_evt_in,
  input  wire logic [127:0] hdr_in,
  input  wire logic [127:0] sec_hdr_in,
  output logic              cfg_ack_out,
  output logic [31:0]       cfg_rdata_out,
  output logic              unc_fatal_out,
  output logic              unc_nonfatal_out,
  output logic              cor_pending_out
);

  logic                rst_meta_r;
  logic                rst_sync_r;
  aec_pkg::aec_word_t  unc_st_r;
  aec_pkg::aec_word_t  unc_mask_r;
  aec_pkg::aec_word_t  unc_sev_r;
  aec_pkg::aec_word_t  cor_st_r;
  aec_pkg::aec_word_t  cor_mask_r;
  aec_pkg::aec_word_t  ctl_r;
  aec_pkg::aec_word_t  sec_st_r;
  aec_pkg::aec_word_t  sec_mask_r;
  aec_pkg::aec_word_t  sec_sev_r;
  aec_pkg::aec_word_t  sec_ctl_r;
  logic [127:0]        hdr_r;
  logic [127:0]        sec_hdr_r;
  aec_pkg::aec_word_t  unc_st_nxt;
  aec_pkg::aec_word_t  cor_st_nxt;
  aec_pkg::aec_word_t  sec_st_nxt;
  aec_pkg::aec_word_t  rdata_nxt;
  aec_pkg::aec_word_t  be_mask;
  aec_pkg::aec_word_t  unc_new;
  aec_pkg::aec_word_t  cor_new;
  aec_pkg::aec_word_t  sec_new;
  logic                wr_en;
  logic                clr_sticky;
  logic                clr_fund;
  logic                clr_hot;
  logic [11:0]         dw_addr;

  // release of the power-on reset goes through two flops; the first is read only by the second
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // widening reset classes: each stronger reset implies the weaker ones
  assign clr_sticky = ~global_reset_n_in;
  assign clr_fund   = clr_sticky | ~perst_n_in;
  assign clr_hot    = clr_fund | hot_reset_in;

  function automatic aec_pkg::aec_word_t be_expand(input logic [3:0] be);
    be_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_expand

  // clears each bit according to its reset class; hot reset never reaches fundamental bits
  function automatic aec_pkg::aec_word_t cls_clear(input aec_pkg::aec_word_t v,
                                                   input logic s, input logic f, input logic h);
    aec_pkg::aec_word_t keep;
    keep = '1;
    if (s) begin
      keep = keep & ~STICKY_MASK;
    end
    if (f) begin
      keep = keep & ~(~STICKY_MASK & ~HOT_MASK);
    end
    if (h) begin
      keep = keep & ~HOT_MASK;
    end
    cls_clear = v & keep;
  endfunction : cls_clear

  // lowest set bit index, used for the first error pointer
  function automatic aec_pkg::aec_ptr_t first_idx(input aec_pkg::aec_word_t v);
    first_idx = '0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        first_idx = aec_pkg::aec_ptr_t'(i);
      end
    end
  endfunction : first_idx

  function automatic aec_pkg::aec_word_t rw_merge(input aec_pkg::aec_word_t old,
                                                  input aec_pkg::aec_word_t wd,
                                                  input aec_pkg::aec_word_t bm,
                                                  input aec_pkg::aec_word_t impl);
    rw_merge = (old & ~(bm & impl)) | (wd & bm & impl);
  endfunction : rw_merge

  assign wr_en   = cfg_req_in & cfg_wr_in;
  assign dw_addr = {cfg_addr_in[11:2], 2'b00};
  assign be_mask = be_expand(cfg_be_in);

  // masked events never reach status or the header log
  assign unc_new = unc_evt_in & ~unc_mask_r & UNC_IMPL_MASK;
  assign cor_new = cor_evt_in & ~cor_mask_r & COR_IMPL_MASK;
  assign sec_new = sec_evt_in & ~sec_mask_r & SEC_IMPL_MASK;

  // status: write one clears, zero leaves; a new event in the clearing cycle still sets
  always_comb begin
    unc_st_nxt = unc_st_r;
    cor_st_nxt = cor_st_r;
    sec_st_nxt = sec_st_r;
    if (wr_en && dw_addr == `AEC_OFF_UNC_STATUS) begin
      unc_st_nxt = unc_st_r & ~(cfg_wdata_in & be_mask);
    end
    if (wr_en && dw_addr == `AEC_OFF_COR_STATUS) begin
      cor_st_nxt = cor_st_r & ~(cfg_wdata_in & be_mask);
    end
    if (wr_en && dw_addr == `AEC_OFF_SEC_STATUS) begin
      sec_st_nxt = sec_st_r & ~(cfg_wdata_in & be_mask);
    end
    unc_st_nxt = cls_clear(unc_st_nxt | unc_new, clr_sticky, clr_fund, clr_hot);
    cor_st_nxt = cls_clear(cor_st_nxt | cor_new, clr_sticky, clr_fund, clr_hot);
    sec_st_nxt = cls_clear(sec_st_nxt | sec_new, clr_sticky, clr_fund, clr_hot);
  end

  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      unc_st_r <= `AEC_RST_WORD;
      cor_st_r <= `AEC_RST_WORD;
      sec_st_r <= `AEC_RST_WORD;
    end else begin
      unc_st_r <= unc_st_nxt;
      cor_st_r <= cor_st_nxt;
      sec_st_r <= sec_st_nxt;
    end
  end

  // mask and severity: plain read/write with byte enables
  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      unc_mask_r <= `AEC_RST_WORD;
      unc_sev_r  <= `AEC_RST_WORD;
      cor_mask_r <= `AEC_RST_WORD;
      sec_mask_r <= `AEC_RST_WORD;
      sec_sev_r  <= `AEC_RST_WORD;
    end else begin
      unc_mask_r <= cls_clear((wr_en && dw_addr == `AEC_OFF_UNC_MASK) ?
                    rw_merge(unc_mask_r, cfg_wdata_in, be_mask, UNC_IMPL_MASK) : unc_mask_r,
                    clr_sticky, clr_fund, clr_hot);
      unc_sev_r  <= cls_clear((wr_en && dw_addr == `AEC_OFF_UNC_SEVERITY) ?
                    rw_merge(unc_sev_r, cfg_wdata_in, be_mask, UNC_IMPL_MASK) : unc_sev_r,
                    clr_sticky, clr_fund, clr_hot);
      cor_mask_r <= cls_clear((wr_en && dw_addr == `AEC_OFF_COR_MASK) ?
                    rw_merge(cor_mask_r, cfg_wdata_in, be_mask, COR_IMPL_MASK) : cor_mask_r,
                    clr_sticky, clr_fund, clr_hot);
      sec_mask_r <= cls_clear((wr_en && dw_addr == `AEC_OFF_SEC_MASK) ?
                    rw_merge(sec_mask_r, cfg_wdata_in, be_mask, SEC_IMPL_MASK) : sec_mask_r,
                    clr_sticky, clr_fund, clr_hot);
      sec_sev_r  <= cls_clear((wr_en && dw_addr == `AEC_OFF_SEC_SEVERITY) ?
                    rw_merge(sec_sev_r, cfg_wdata_in, be_mask, SEC_IMPL_MASK) : sec_sev_r,
                    clr_sticky, clr_fund, clr_hot);
    end
  end

  // control: software bits plus a first error pointer that hardware loads on the first error
  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctl_r     <= `AEC_RST_WORD;
      sec_ctl_r <= `AEC_RST_WORD;
    end else begin
      aec_pkg::aec_word_t c;
      aec_pkg::aec_word_t sc;
      c  = (wr_en && dw_addr == `AEC_OFF_CAP_CTRL) ?
           rw_merge(ctl_r, cfg_wdata_in, be_mask, CTL_RW_MASK) : ctl_r;
      sc = (wr_en && dw_addr == `AEC_OFF_SEC_CTRL) ?
           rw_merge(sec_ctl_r, cfg_wdata_in, be_mask, CTL_RW_MASK) : sec_ctl_r;
      if (unc_new != '0 && unc_st_r == '0) begin
        c[`AEC_FEP_LSB +: `AEC_FEP_W] = first_idx(unc_new);
      end
      if (sec_new != '0 && sec_st_r == '0) begin
        sc[`AEC_FEP_LSB +: `AEC_FEP_W] = first_idx(sec_new);
      end
      ctl_r     <= cls_clear(c, clr_sticky, clr_fund, clr_hot);
      sec_ctl_r <= cls_clear(sc, clr_sticky, clr_fund, clr_hot);
    end
  end

  // header logs capture an unmasked error only while status is empty, so later errors cannot overwrite it until status is cleared
  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      hdr_r     <= '0;
      sec_hdr_r <= '0;
    end else begin
      if (clr_fund) begin
        hdr_r <= '0;
      end else if (unc_new != '0 && unc_st_r == '0) begin
        hdr_r <= hdr_in;
      end
      if (clr_fund) begin
        sec_hdr_r <= '0;
      end else if (sec_new != '0 && sec_st_r == '0) begin
        sec_hdr_r <= sec_hdr_in;
      end
    end
  end

  // read decode; the identifier dword is fixed so writes to it have nothing to land in
  always_comb begin
    case (dw_addr)
      `AEC_OFF_CAP_ID:       rdata_nxt = {`AEC_NEXT_PTR_VAL, `AEC_CAP_VER_VAL, `AEC_CAP_ID_VAL};
      `AEC_OFF_UNC_STATUS:   rdata_nxt = unc_st_r;
      `AEC_OFF_UNC_MASK:     rdata_nxt = unc_mask_r;
      `AEC_OFF_UNC_SEVERITY: rdata_nxt = unc_sev_r;
      `AEC_OFF_COR_STATUS:   rdata_nxt = cor_st_r;
      `AEC_OFF_COR_MASK:     rdata_nxt = cor_mask_r;
      `AEC_OFF_CAP_CTRL:     rdata_nxt = ctl_r;
      `AEC_OFF_HDR_LOG0:     rdata_nxt = hdr_r[31:0];
      `AEC_OFF_HDR_LOG1:     rdata_nxt = hdr_r[63:32];
      `AEC_OFF_HDR_LOG2:     rdata_nxt = hdr_r[95:64];
      `AEC_OFF_HDR_LOG3:     rdata_nxt = hdr_r[127:96];
      `AEC_OFF_SEC_STATUS:   rdata_nxt = sec_st_r;
      `AEC_OFF_SEC_MASK:     rdata_nxt = sec_mask_r;
      `AEC_OFF_SEC_SEVERITY: rdata_nxt = sec_sev_r;
      `AEC_OFF_SEC_CTRL:     rdata_nxt = sec_ctl_r;
      `AEC_OFF_SEC_LOG0:     rdata_nxt = sec_hdr_r[31:0];
      `AEC_OFF_SEC_LOG1:     rdata_nxt = sec_hdr_r[63:32];
      `AEC_OFF_SEC_LOG2:     rdata_nxt = sec_hdr_r[95:64];
      `AEC_OFF_SEC_LOG3:     rdata_nxt = sec_hdr_r[127:96];
      default:               rdata_nxt = `AEC_RST_WORD;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cfg_ack_out   <= 1'b0;
      cfg_rdata_out <= `AEC_RST_WORD;
    end else begin
      cfg_ack_out   <= cfg_req_in;
      cfg_rdata_out <= (cfg_req_in && !cfg_wr_in) ? rdata_nxt : `AEC_RST_WORD;
    end
  end

  // summaries reflect registered status, so they trail the status by one cycle
  always_ff @(posedge mclk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      unc_fatal_out    <= 1'b0;
      unc_nonfatal_out <= 1'b0;
      cor_pending_out  <= 1'b0;
    end else begin
      unc_fatal_out    <= |(unc_st_r & unc_sev_r) | |(sec_st_r & sec_sev_r);
      unc_nonfatal_out <= |(unc_st_r & ~unc_sev_r) | |(sec_st_r & ~sec_sev_r);
      cor_pending_out  <= |cor_st_r;
    end
  end

endmodule : aec_top

// >>> testbench/aec_cfg_host.sv
// Purpose: upstream requester issuing config reads and writes
// Assumes: one-cycle request strobe, ack one edge after the take edge
// Notes:   released address, byte enable and data fields are inverted so stale values never look valid
module aec_cfg_host (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] rdata_in,
  output logic             req_out,
  output logic             wr_out,
  output logic [11:0]      addr_out,
  output logic [3:0]       be_out,
  output logic [31:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {req_out, wr_out, addr_out, be_out, wdata_out} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
                      output logic got_ack, output logic [31:0] got);
    @(posedge clk_in);
    req_out <= 1'b1;
    wr_out <= w;
    addr_out <= a;
    be_out <= b;
    wdata_out <= d;
    @(posedge clk_in);
    req_out <= 1'b0;
    addr_out <= ~a;
    be_out <= ~b;
    wdata_out <= ~d;
    #1;
    got_ack = ack_in;
    got = rdata_in;
  endtask : xfer
endmodule : aec_cfg_host

// >>> testbench/aec_top_assertions.sv
// Purpose: port-level checks of the error reporting register bank
// Assumes: single clock domain, rst_n_in disables every check
// Notes:   register contents are judged by the bench model
module aec_chk (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        global_reset_n_in,
  input wire logic        perst_n_in,
  input wire logic        cfg_req_in,
  input wire logic        cfg_wr_in,
  input wire logic [11:0] cfg_addr_in,
  input wire logic        cfg_ack_out,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        unc_fatal_out,
  input wire logic        unc_nonfatal_out,
  input wire logic        cor_pending_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic rd_c;
  assign rd_c = cfg_req_in && !cfg_wr_in;
  AST_ACK_NEXT: assert property (cfg_req_in |=> cfg_ack_out) else $error("ack missing after request");
  AST_ACK_CAUSE: assert property (cfg_ack_out |-> $past(cfg_req_in)) else $error("ack without request");
  AST_CAP_HDR: assert property (rd_c && cfg_addr_in[11:2] == 10'h040 |=> cfg_rdata_out == 32'h00010001)
    else $error("capability header dword wrong");
  AST_RSVD_ZERO: assert property (rd_c && cfg_addr_in[11:2] > 10'h052 |=> cfg_rdata_out == 32'h0)
    else $error("reserved read not zero");
  AST_WR_NO_DATA: assert property (cfg_req_in && cfg_wr_in |=> cfg_rdata_out == 32'h0) else $error("write gave data");
  AST_IDLE_ZERO: assert property (!cfg_ack_out |-> cfg_rdata_out == 32'h0) else $error("data without ack");
  AST_GLOBAL_RESET_INPUT_CLEAR: assert property (!global_reset_n_in ##1 (rd_c && cfg_addr_in[11:2] inside {[10'h041:10'h052]})
    |=> cfg_rdata_out == 32'h0) else $error("register survived global reset");
  AST_PERST_LOG: assert property (!perst_n_in ##1 (rd_c && cfg_addr_in[11:2] inside {[10'h047:10'h04A]})
    |=> cfg_rdata_out == 32'h0) else $error("header log survived fundamental reset");
  AST_SUMMARY_CLEAR: assert property (!global_reset_n_in
    |-> ##2 !(unc_fatal_out || unc_nonfatal_out || cor_pending_out))
    else $error("summary set after global reset");
  COV_CAP_READ: cover property (rd_c && cfg_addr_in[11:2] == 10'h040);
  COV_GLOBAL_RESET_INPUT: cover property (!global_reset_n_in);
  COV_PERST: cover property (!perst_n_in);
  COV_PENDING: cover property (cor_pending_out && unc_fatal_out);
endmodule : aec_chk
bind aec_top aec_chk u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .global_reset_n_in(global_reset_n_in),
  .perst_n_in(perst_n_in), .cfg_req_in(cfg_req_in), .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in),
  .cfg_ack_out(cfg_ack_out), .cfg_rdata_out(cfg_rdata_out), .unc_fatal_out(unc_fatal_out),
  .unc_nonfatal_out(unc_nonfatal_out), .cor_pending_out(cor_pending_out));

// >>> testbench/tb.sv
// Purpose: model-based bench for the error reporting register bank
// Assumes: design masks as defaults; sticky and hot classes set here to exercise reset classes
// Notes:   model entries are indexed by dword offset within the extended space
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] UNC = 32'h001FF010, COR = 32'h000031C1, SEC = 32'h00001FFF, CTL = 32'h00000140;
  localparam logic [31:0] STK = 32'h00000140, HOT = 32'h00010000;
  logic         mclk_in = 1'b0, rst_n_in = 1'b0, global_reset_input_n = 1'b1, perst_n = 1'b1, hot = 1'b0;
  logic [31:0]  unc_evt = '0, cor_evt = '0, sec_evt = '0, wdata, rdata;
  logic [127:0] hdr = '0, sec_hdr = '0;
  logic         req, wr, ack, fatal, nonfatal, cor_pend;
  logic [11:0]  addr;
  logic [3:0]   be;
  logic [31:0]  mdl [0:1023];
  int           err_count = 0, n_compared = 0, seed = 69129;
  int           wa [9] = '{'h108, 'h10C, 'h114, 'h118, 'h130, 'h134, 'h138, 'h14C, 'hFFC};
  always #10 mclk_in = ~mclk_in;
  aec_cfg_host host (.clk_in(mclk_in), .ack_in(ack), .rdata_in(rdata), .req_out(req), .wr_out(wr),
    .addr_out(addr), .be_out(be), .wdata_out(wdata));
  aec_top #(.STICKY_MASK(STK), .HOT_MASK(HOT)) DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .global_reset_n_in(global_reset_input_n), .perst_n_in(perst_n), .hot_reset_in(hot), .cfg_req_in(req), .cfg_wr_in(wr),
    .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wdata), .unc_evt_in(unc_evt), .cor_evt_in(cor_evt),
    .sec_evt_in(sec_evt), .hdr_in(hdr), .sec_hdr_in(sec_hdr), .cfg_ack_out(ack), .cfg_rdata_out(rdata),
    .unc_fatal_out(fatal), .unc_nonfatal_out(nonfatal), .cor_pending_out(cor_pend));
  function automatic logic [31:0] wmsk(input int a);
    case (a)
      'h104, 'h108, 'h10C: return UNC;
      'h110, 'h114:        return COR;
      'h12C, 'h130, 'h134: return SEC;
      'h118, 'h138:        return CTL;
      default:             return 32'h00000000;
    endcase
  endfunction : wmsk
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cfg(input logic w, input int a, input logic [3:0] b, input logic [31:0] d);
    logic        got_ack;
    logic [31:0] got, m;
    m = wmsk(a) & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    host.xfer(w, a[11:0], b, d, got_ack, got);
    chk({31'h0, got_ack}, 32'h1);
    if (!w) chk(got, mdl[a >> 2]);
    else if (a inside {'h104, 'h110, 'h12C}) mdl[a >> 2] &= ~(d & m);
    else mdl[a >> 2] = (mdl[a >> 2] & ~m) | (d & m);
  endtask : cfg
  task automatic chk_all;
    for (int a = 'h100; a <= 'h150; a += 4) cfg(1'b0, a, 4'hF, 32'h0);
    cfg(1'b0, 'hFFC, 4'hF, 32'h0);
  endtask : chk_all
  // k: 0 hot reset, 1 fundamental reset, 2 global reset
  task automatic rst_evt(input int k);
    @(posedge mclk_in);
    global_reset_input_n <= (k != 2);
    perst_n <= (k != 1);
    hot <= (k == 0);
    for (int a = 'h104; a <= 'h148; a += 4)
      if (a < 'h11C || (a >= 'h12C && a < 'h13C)) mdl[a >> 2] &= (k == 0) ? ~HOT : (k == 1) ? STK : 32'h0;
      else if (k != 0) mdl[a >> 2] = 32'h0;
    // the read is taken on the edge right after the reset edge, so it sees the cleared state at once
    fork
      begin
        @(posedge mclk_in);
        {global_reset_input_n, perst_n, hot} <= 3'b110;
      end
      cfg(1'b0, (k == 1) ? 'h11C : 'h104, 4'hF, 32'h0);
    join
  endtask : rst_evt
  task automatic ev(input logic [31:0] u, input logic [31:0] c, input logic [31:0] s);
    logic [31:0]  su, ss;
    logic [127:0] h, sh;
    logic [4:0]   f;
    su = u & UNC & ~mdl[66];
    ss = s & SEC & ~mdl[76];
    h = {$random(seed), $random(seed), $random(seed), $random(seed)};
    sh = {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge mclk_in);
    {unc_evt, cor_evt, sec_evt, hdr, sec_hdr} <= {u, c, s, h, sh};
    @(posedge mclk_in);
    {unc_evt, cor_evt, sec_evt} <= '0;
    f = 5'h0;
    // log and pointer only capture the first error while status is empty
    if (mdl[65] == 0 && su != 0) begin
      for (int j = 31; j >= 0; j--) if (su[j]) f = 5'(j);
      mdl[70] = (mdl[70] & ~32'h1F) | {27'h0, f};
      for (int j = 0; j < 4; j++) mdl[71 + j] = h[32 * j +: 32];
    end
    if (mdl[75] == 0 && ss != 0) begin
      f = 5'h0;
      for (int j = 31; j >= 0; j--) if (ss[j]) f = 5'(j);
      mdl[78] = (mdl[78] & ~32'h1F) | {27'h0, f};
      for (int j = 0; j < 4; j++) mdl[79 + j] = sh[32 * j +: 32];
    end
    mdl[65] |= su;
    mdl[68] |= c & COR & ~mdl[69];
    mdl[75] |= ss;
    @(posedge mclk_in);
    #1;
    chk({31'h0, cor_pend}, {31'h0, mdl[68] != 0});
    chk({31'h0, fatal}, {31'h0, ((mdl[65] & mdl[67]) | (mdl[75] & mdl[77])) != 0});
    chk({31'h0, nonfatal}, {31'h0, ((mdl[65] & ~mdl[67]) | (mdl[75] & ~mdl[77])) != 0});
  endtask : ev
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    give_verdict;
  end
  initial begin
    for (int i = 0; i < 1024; i++) mdl[i] = 32'h0;
    mdl[64] = 32'h00010001;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk_all;
    cfg(1'b1, 'h100, 4'hF, 32'hFFFFFFFF);
    cfg(1'b1, 'h102, 4'hF, 32'hFFFFFFFF);
    cfg(1'b0, 'h102, 4'hF, 32'h0);
    for (int i = 0; i < 18; i++) cfg(1'b1, wa[i % 9], 4'($random(seed)), $random(seed));
    chk_all;
    repeat (3) ev($random(seed), $random(seed), $random(seed));
    chk_all;
    for (int i = 0; i < 6; i++) cfg(1'b1, (i % 3 == 0) ? 'h104 : (i % 3 == 1) ? 'h110 : 'h12C, 4'hF,
      (i < 3) ? 32'h0 : $random(seed));
    chk_all;
    ev(32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF);
    rst_evt(0);
    chk_all;
    rst_evt(1);
    chk_all;
    ev($random(seed), $random(seed), $random(seed));
    rst_evt(2);
    chk_all;
    give_verdict;
  end
endmodule : tb
